// ===== src/dma5_pkg.sv
// Purpose: Shared constants, register map and carrier types of the five-channel DMA controller.
// Assumes: Word-indexed register port, 16-bit data memory addresses and data.
// Notes: Channel register blocks repeat at a fixed stride above the global registers.
package dma5_pkg;
  localparam int NUM_CHANNELS = 5;
  localparam int ADDR_WIDTH = 16;
  localparam int DATA_WIDTH = 16;
  localparam int LEN_WIDTH = 13;
  localparam int REG_DATA_WIDTH = 32;
  localparam int REG_ADDR_WIDTH = 8;
  localparam int TRIG_COUNT = 31;
  localparam int CFG_BITS = 19;

  localparam logic [7:0] REG_CHANNEL_ARM = 8'h00;
  localparam logic [7:0] REG_SOFT_REQUEST = 8'h01;
  localparam logic [7:0] REG_COMPLETION_FLAG = 8'h02;
  localparam logic [7:0] REG_ENGINE_STATUS = 8'h03;
  localparam logic [5:0] REG_CH_BASE_WORD = 6'h04;
  localparam logic [1:0] CH_SRC_OFS = 2'h0;
  localparam logic [1:0] CH_DST_OFS = 2'h1;
  localparam logic [1:0] CH_LIMIT_OFS = 2'h2;
  localparam logic [1:0] CH_CFG_OFS = 2'h3;

  localparam int ARM_ABORT_BIT = 7;
  localparam int STATUS_BUSY_BIT = 7;
  localparam int WORD_LEN_MSB = 12;

  localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 16'h0000;
  localparam logic [LEN_WIDTH-1:0] LIMIT_RESET = 13'h0000;
  localparam logic [CFG_BITS-1:0] CFG_RESET = 19'h00000;

  localparam logic [1:0] PRIO_LOW = 2'h0;
  localparam logic [1:0] PRIO_NORMAL = 2'h1;
  localparam logic [1:0] PRIO_HIGH = 2'h2;

  localparam logic [2:0] VARIABLE_LENGTH_OPTION_FIXED = 3'h0;
  localparam logic [2:0] VARIABLE_LENGTH_OPTION_PLUS_ONE = 3'h1;
  localparam logic [2:0] VARIABLE_LENGTH_OPTION_EXACT = 3'h2;
  localparam logic [2:0] VARIABLE_LENGTH_OPTION_PLUS_TWO = 3'h3;
  localparam logic [2:0] VARIABLE_LENGTH_OPTION_PLUS_THREE = 3'h4;

  typedef enum logic [1:0] {TM_SINGLE, TM_BLOCK, TM_REP_SINGLE, TM_REP_BLOCK} xfer_mode_e;
  typedef enum logic [1:0] {STEP_NONE, STEP_ONE, STEP_TWO, STEP_BACK} addr_step_e;

  typedef struct packed {
    logic completionIrqMask;
    logic [1:0] prio;
    addr_step_e dstStep;
    addr_step_e srcStep;
    logic lengthByteWidthSel;
    logic wordSize;
    logic [2:0] variableLengthOption;
    xfer_mode_e mode;
    logic [4:0] trigSel;
  } chan_cfg_s;

  typedef struct packed {
    logic en;
    logic write;
    logic word;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
  } mem_cmd_s;
endpackage

// ===== src/five_channel_dma.sv
// Purpose: Five-channel DMA engine moving bytes or words through the external data space.
// Assumes: Memory returns read data in the cycle after the access cycle; one access per cycle.
// Notes: Channel setup lives in registers reached over the plain register port.
// Summary of operation
// - Five independent channels, numbered zero to four, copy data between memory locations.
// - No channel transfers until software sets its bit in the arm register.
// - An armed channel starts on its selected trigger event among thirty sources.
// - Setting an armed channel's software request bit starts a transfer; an unarmed channel ignores it.
// - One trigger source per channel; it starts one item or a whole block.
// - The source setting is the first location read.
// - After the count, the channel rearms or disarms and raises a completion request.
// - Variable length takes the count from the first item; words use bits 12 to 0.
// - The fixed length acts as the upper limit in every variable-length option.
// - For byte transfers a width bit picks seven or eight length bits.
// - Option one moves length item plus count; option two moves exactly the count.
// - Options three and four move length item then count plus one or two.
// - Arming or rearming loads source and destination into working pointers.
// - Each pointer independently stays, adds one, adds two or subtracts one per item.
// - A size setting makes each item one byte or one 16-bit word.
// - A mask bit decides whether completion raises an interrupt request.
// - Mode selects single, block, repeated single or repeated block.
// - Three priority levels arbitrate between channels and against the processor.
// - The whole external data space, registers included, is addressable.
// - Single moves one item per trigger, block the whole count; repeats rearm.
// - High beats processor, normal wins every second try, low yields; ties rotate.
// - An arm write with abort set disarms the selected channels and stops them.
// - The completion flag sets regardless of mask; the mask gates only the request.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module five_channel_dma
  import dma5_pkg::*;
#(
  parameter int NUM_CH = NUM_CHANNELS
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [REG_ADDR_WIDTH-1:0] regAddr,
  input wire logic [REG_DATA_WIDTH-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [REG_DATA_WIDTH-1:0] regRdata,
  input wire logic [TRIG_COUNT-1:0] trigIn,
  input wire logic cpuReq,
  output mem_cmd_s memCmd,
  input wire logic [DATA_WIDTH-1:0] memRdata,
  output logic [NUM_CH-1:0] irqReq,
  output logic dmaBusy
);

  if (NUM_CH < 1 || NUM_CH > ARM_ABORT_BIT) begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 7");
  end

  typedef enum logic [1:0] {S_IDLE, S_RD, S_CAP, S_WR} eng_state_e;

  eng_state_e state_q;
  logic [2:0] cur_q;
  logic [2:0] rr_q;
  logic normDeferred_q;
  logic [NUM_CH-1:0] armed_q;
  logic [NUM_CH-1:0] pend_q;
  logic [NUM_CH-1:0] flag_q;
  logic [NUM_CH-1:0] first_q;
  logic [NUM_CH-1:0] irq_q;
  logic busy_q;
  logic [REG_DATA_WIDTH-1:0] rdata_q;
  mem_cmd_s cmd_q;
  chan_cfg_s cfg_q [NUM_CH];
  logic [ADDR_WIDTH-1:0] srcCfg_q [NUM_CH];
  logic [ADDR_WIDTH-1:0] dstCfg_q [NUM_CH];
  logic [LEN_WIDTH-1:0] limit_q [NUM_CH];
  logic [ADDR_WIDTH-1:0] srcPtr_q [NUM_CH];
  logic [ADDR_WIDTH-1:0] dstPtr_q [NUM_CH];
  logic [LEN_WIDTH:0] rem_q [NUM_CH];

  function automatic logic chHit(input logic [REG_ADDR_WIDTH-1:0] a, input int n);
    return a[7:2] == 6'(int'(REG_CH_BASE_WORD) + n);
  endfunction

  function automatic logic [1:0] prioLevel(input logic [1:0] p);
    return (p > PRIO_HIGH) ? PRIO_HIGH : p;
  endfunction

  function automatic logic [ADDR_WIDTH-1:0] stepAddr(input logic [ADDR_WIDTH-1:0] a,
                                                     input addr_step_e s);
    logic [ADDR_WIDTH-1:0] r;
    r = a;
    unique case (s)
      STEP_NONE: r = a;
      STEP_ONE: r = a + 16'h0001;
      STEP_TWO: r = a + 16'h0002;
      STEP_BACK: r = a - 16'h0001;
    endcase
    return r;
  endfunction

  logic armWr;
  logic abortWr;
  logic softWr;
  logic flagWr;
  logic [NUM_CH-1:0] wrBits;
  logic [NUM_CH-1:0] abortBits;
  logic [NUM_CH-1:0] armLoad;
  logic [NUM_CH-1:0] trigHit;
  logic [NUM_CH-1:0] pendAct;
  logic found;
  logic go;
  logic [2:0] win;
  logic [1:0] winLvl;
  chan_cfg_s curCfg;
  logic isLenItem;
  logic exactOpt;
  logic [LEN_WIDTH:0] lenVal;
  logic [LEN_WIDTH:0] want;
  logic [LEN_WIDTH:0] limEff;
  logic [LEN_WIDTH:0] capLimit;
  logic [LEN_WIDTH:0] remAfter;
  logic [LEN_WIDTH:0] loadRem;
  logic curArmed;
  logic capEnd;
  logic itemEnd;
  logic finish;
  logic repeatMode;
  logic singleMode;

  assign armWr = regWrite && regAddr == REG_CHANNEL_ARM;
  assign abortWr = armWr && regWdata[ARM_ABORT_BIT];
  assign softWr = regWrite && regAddr == REG_SOFT_REQUEST;
  assign flagWr = regWrite && regAddr == REG_COMPLETION_FLAG;
  assign wrBits = regWdata[NUM_CH-1:0];
  assign abortBits = abortWr ? wrBits : '0;
  assign pendAct = pend_q & armed_q;
  assign curCfg = cfg_q[cur_q];
  assign curArmed = armed_q[cur_q];
  assign repeatMode = curCfg.mode == TM_REP_SINGLE || curCfg.mode == TM_REP_BLOCK;
  assign singleMode = curCfg.mode == TM_SINGLE || curCfg.mode == TM_REP_SINGLE;

  // Trigger number zero means software request only; numbers past the bus width never fire.
  for (genvar n = 0; n < NUM_CH; n++) begin : g_trig
    assign trigHit[n] = cfg_q[n].trigSel != 5'h00 &&
                        int'(cfg_q[n].trigSel) < TRIG_COUNT &&
                        trigIn[cfg_q[n].trigSel];
    assign armLoad[n] = (armWr && !regWdata[ARM_ABORT_BIT] && wrBits[n] && !armed_q[n]) ||
                        (finish && repeatMode && int'(cur_q) == n);
  end

  // Round-robin scan starts after the last winner so equal levels take turns.
  always_comb begin
    int idx;
    logic [1:0] lvl;
    idx = 0;
    lvl = PRIO_LOW;
    found = 1'b0;
    win = 3'h0;
    winLvl = PRIO_LOW;
    for (int k = 1; k <= NUM_CH; k++) begin
      idx = (int'(rr_q) + k) % NUM_CH;
      lvl = prioLevel(cfg_q[idx].prio);
      if (pendAct[idx] && (!found || lvl > winLvl)) begin
        found = 1'b1;
        win = 3'(idx);
        winLvl = lvl;
      end
    end
  end

  assign go = found && (winLvl == PRIO_HIGH || !cpuReq ||
                        (winLvl == PRIO_NORMAL && normDeferred_q));

  // Length item decode; the fixed limit caps the total, counting the length item when it moves.
  always_comb begin
    if (curCfg.wordSize) begin
      lenVal = {1'b0, memRdata[WORD_LEN_MSB:0]};
    end else if (curCfg.lengthByteWidthSel) begin
      lenVal = {7'h00, memRdata[6:0]};
    end else begin
      lenVal = {6'h00, memRdata[7:0]};
    end
    unique case (curCfg.variableLengthOption)
      VARIABLE_LENGTH_OPTION_PLUS_TWO: want = lenVal + 14'h0001;
      VARIABLE_LENGTH_OPTION_PLUS_THREE: want = lenVal + 14'h0002;
      default: want = lenVal;
    endcase
    limEff = (limit_q[cur_q] == LIMIT_RESET) ? 14'h0001 : {1'b0, limit_q[cur_q]};
    capLimit = exactOpt ? limEff : limEff - 14'h0001;
    remAfter = (want < capLimit) ? want : capLimit;
    loadRem = exactOpt ? remAfter : remAfter + 14'h0001;
  end

  assign isLenItem = first_q[cur_q] && curCfg.variableLengthOption >= VARIABLE_LENGTH_OPTION_PLUS_ONE &&
                     curCfg.variableLengthOption <= VARIABLE_LENGTH_OPTION_PLUS_THREE;
  assign exactOpt = curCfg.variableLengthOption == VARIABLE_LENGTH_OPTION_EXACT;
  assign capEnd = state_q == S_CAP && curArmed && isLenItem && exactOpt &&
                  remAfter == 14'h0000;
  assign itemEnd = curArmed && (state_q == S_WR || capEnd);
  assign finish = itemEnd && (capEnd || rem_q[cur_q] <= 14'h0001);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int n = 0; n < NUM_CH; n++) begin
        cfg_q[n] <= chan_cfg_s'(CFG_RESET);
        srcCfg_q[n] <= ADDR_RESET;
        dstCfg_q[n] <= ADDR_RESET;
        limit_q[n] <= LIMIT_RESET;
      end
    end else if (ce && regWrite) begin
      for (int n = 0; n < NUM_CH; n++) begin
        if (chHit(regAddr, n)) begin
          unique case (regAddr[1:0])
            CH_SRC_OFS: srcCfg_q[n] <= regWdata[ADDR_WIDTH-1:0];
            CH_DST_OFS: dstCfg_q[n] <= regWdata[ADDR_WIDTH-1:0];
            CH_LIMIT_OFS: limit_q[n] <= regWdata[LEN_WIDTH-1:0];
            CH_CFG_OFS: cfg_q[n] <= chan_cfg_s'(regWdata[CFG_BITS-1:0]);
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armed_q <= '0;
    end else if (ce) begin
      for (int n = 0; n < NUM_CH; n++) begin
        if (abortBits[n]) begin
          armed_q[n] <= 1'b0;
        end else if (armWr && wrBits[n]) begin
          armed_q[n] <= 1'b1;
        end else if (finish && int'(cur_q) == n && !repeatMode) begin
          armed_q[n] <= 1'b0;
        end
      end
    end
  end

  // A request arriving while its clear fires is kept; a disarmed channel drops its request.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= '0;
    end else if (ce) begin
      for (int n = 0; n < NUM_CH; n++) begin
        if (armed_q[n] && !abortBits[n] && (trigHit[n] || (softWr && wrBits[n]))) begin
          pend_q[n] <= 1'b1;
        end else if (abortBits[n] || !armed_q[n]) begin
          pend_q[n] <= 1'b0;
        end else if (itemEnd && int'(cur_q) == n && (singleMode || finish)) begin
          pend_q[n] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int n = 0; n < NUM_CH; n++) begin
        srcPtr_q[n] <= ADDR_RESET;
        dstPtr_q[n] <= ADDR_RESET;
        rem_q[n] <= '0;
        first_q[n] <= 1'b0;
      end
    end else if (ce) begin
      for (int n = 0; n < NUM_CH; n++) begin
        if (armLoad[n]) begin
          srcPtr_q[n] <= srcCfg_q[n];
          dstPtr_q[n] <= dstCfg_q[n];
          rem_q[n] <= {1'b0, limit_q[n]};
          first_q[n] <= 1'b1;
        end else if (int'(cur_q) == n && curArmed) begin
          if (state_q == S_CAP) begin
            srcPtr_q[n] <= stepAddr(srcPtr_q[n], cfg_q[n].srcStep);
            first_q[n] <= 1'b0;
            if (isLenItem) begin
              rem_q[n] <= loadRem;
            end
          end else if (state_q == S_WR) begin
            dstPtr_q[n] <= stepAddr(dstPtr_q[n], cfg_q[n].dstStep);
            if (rem_q[n] > 14'h0001) begin
              rem_q[n] <= rem_q[n] - 14'h0001;
            end
          end
        end
      end
    end
  end

  // One access per cycle: the engine serves a single channel from read to write.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      cur_q <= 3'h0;
      rr_q <= 3'h0;
      cmd_q <= '0;
      busy_q <= 1'b0;
    end else if (ce) begin
      cmd_q.en <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          if (go) begin
            state_q <= S_RD;
            cur_q <= win;
            rr_q <= win;
            cmd_q <= '{en: 1'b1, write: 1'b0, word: cfg_q[win].wordSize,
                       addr: srcPtr_q[win], wdata: '0};
            busy_q <= 1'b1;
          end
        end
        S_RD: state_q <= S_CAP;
        S_CAP: begin
          if (!curArmed || capEnd) begin
            state_q <= S_IDLE;
            busy_q <= 1'b0;
          end else if (isLenItem && exactOpt) begin
            state_q <= S_RD;
            cmd_q <= '{en: 1'b1, write: 1'b0, word: curCfg.wordSize,
                       addr: stepAddr(srcPtr_q[cur_q], curCfg.srcStep), wdata: '0};
          end else begin
            state_q <= S_WR;
            cmd_q <= '{en: 1'b1, write: 1'b1, word: curCfg.wordSize, addr: dstPtr_q[cur_q],
                       wdata: curCfg.wordSize ? memRdata : {8'h00, memRdata[7:0]}};
          end
        end
        S_WR: begin
          state_q <= S_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      normDeferred_q <= 1'b0;
    end else if (ce && state_q == S_IDLE && found && winLvl == PRIO_NORMAL) begin
      normDeferred_q <= !go;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= '0;
      irq_q <= '0;
    end else if (ce) begin
      for (int n = 0; n < NUM_CH; n++) begin
        if (finish && int'(cur_q) == n) begin
          flag_q[n] <= 1'b1;
        end else if (flagWr && wrBits[n]) begin
          flag_q[n] <= 1'b0;
        end
        irq_q[n] <= finish && int'(cur_q) == n && cfg_q[n].completionIrqMask;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else if (ce) begin
      rdata_q <= '0;
      if (regRead) begin
        if (regAddr == REG_CHANNEL_ARM) begin
          rdata_q <= 32'(armed_q);
        end else if (regAddr == REG_SOFT_REQUEST) begin
          rdata_q <= 32'(pend_q);
        end else if (regAddr == REG_COMPLETION_FLAG) begin
          rdata_q <= 32'(flag_q);
        end else if (regAddr == REG_ENGINE_STATUS) begin
          rdata_q[STATUS_BUSY_BIT] <= busy_q;
          rdata_q[2:0] <= cur_q;
        end
        for (int n = 0; n < NUM_CH; n++) begin
          if (chHit(regAddr, n)) begin
            unique case (regAddr[1:0])
              CH_SRC_OFS: rdata_q <= 32'(srcCfg_q[n]);
              CH_DST_OFS: rdata_q <= 32'(dstCfg_q[n]);
              CH_LIMIT_OFS: rdata_q <= 32'(limit_q[n]);
              CH_CFG_OFS: rdata_q <= 32'(cfg_q[n]);
            endcase
          end
        end
      end
    end
  end

  assign regRdata = rdata_q;
  assign memCmd = cmd_q;
  assign irqReq = irq_q;
  assign dmaBusy = busy_q;

endmodule

// ===== test/five_channel_dma_checker.sv
// Purpose: Port assertions for the five-channel DMA engine.
// Assumes: ce stays high while checked.
// Notes: An item is a read, a capture cycle and a write, or a second read after a length item.
`timescale 1ns/1ps
module five_channel_dma_checker
  import dma5_pkg::*;
#(
  parameter int NUM_CH = NUM_CHANNELS
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [REG_ADDR_WIDTH-1:0] regAddr,
  input wire logic [REG_DATA_WIDTH-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [REG_DATA_WIDTH-1:0] regRdata,
  input wire logic [TRIG_COUNT-1:0] trigIn,
  input wire logic cpuReq,
  input mem_cmd_s memCmd,
  input wire logic [DATA_WIDTH-1:0] memRdata,
  input wire logic [NUM_CH-1:0] irqReq,
  input wire logic dmaBusy
);
  logic rdAcc;
  logic wrAcc;
  logic abortAll;
  assign rdAcc = memCmd.en && !memCmd.write;
  assign wrAcc = memCmd.en && memCmd.write;
  assign abortAll = regWrite && regAddr == REG_CHANNEL_ARM && regWdata[7:0] == 8'h9F;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst || !ce);
  a_read_then_write: assert property (rdAcc |=> !memCmd.en ##1 (wrAcc || rdAcc || !dmaBusy))
    else $error("read not followed by write");
  a_write_gap: assert property (wrAcc |=> !memCmd.en)
    else $error("access right after write");
  a_busy_item: assert property (rdAcc |-> dmaBusy [*2] ##1 (dmaBusy == memCmd.en))
    else $error("busy dropped inside item");
  a_irq_pulse: assert property (|irqReq |=> irqReq == '0)
    else $error("irq longer than one cycle");
  a_irq_single: assert property ($onehot0(irqReq))
    else $error("two completions at once");
  a_irq_after_write: assert property (|irqReq |-> $past(wrAcc))
    else $error("irq without final write");
  a_byte_upper_zero: assert property (wrAcc && !memCmd.word |-> memCmd.wdata[15:8] == 8'h00)
    else $error("byte write upper data set");
  // The in-flight item may still finish, so silence is demanded only after it.
  a_abort_quiet: assert property (abortAll |=> ##3 !memCmd.en [*8])
    else $error("access after full abort");
  c_read: cover property (rdAcc);
  c_irq: cover property (|irqReq);
  c_abort: cover property (abortAll);
endmodule

bind five_channel_dma five_channel_dma_checker #(.NUM_CH(NUM_CH)) u_five_channel_dma_checker (
  .core_clk(core_clk), .nrst(nrst), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .trigIn(trigIn),
  .cpuReq(cpuReq), .memCmd(memCmd), .memRdata(memRdata), .irqReq(irqReq), .dmaBusy(dmaBusy));

// ===== test/mem_partner.sv
// Purpose: Byte-addressed data memory answering the DMA engine.
// Assumes: Only the low 8 address bits are decoded.
// Notes: Read data is valid for exactly one cycle.
`timescale 1ns/1ps
module mem_partner
  import dma5_pkg::*;
(
  input wire logic core_clk,
  input mem_cmd_s memCmd,
  output logic [DATA_WIDTH-1:0] memRdata
);
  logic [7:0] mem [0:255];
  logic [7:0] a;
  assign a = memCmd.addr[7:0];
  initial memRdata = '0;
  always @(posedge core_clk) begin
    if (memCmd.en && memCmd.write) begin
      mem[a] <= memCmd.wdata[7:0];
      if (memCmd.word) begin
        mem[a + 8'h01] <= memCmd.wdata[15:8];
      end
    end
    if (memCmd.en && !memCmd.write) begin
      memRdata <= memCmd.word ? {mem[a + 8'h01], mem[a]} : {8'h00, mem[a]};
    end else begin
      // Toggling exposes a capture taken in the wrong cycle.
      memRdata <= ~memRdata;
    end
  end
endmodule

// ===== test/tb_top.sv
// Purpose: Self-checking bench for the five-channel DMA engine.
// Assumes: ce high except in one freeze check; source byte at address a holds a unless overwritten.
// Notes: Item counts come from a monitor of memory writes.
`timescale 1ns/1ps
module tb_top;
  import dma5_pkg::*;
  logic core_clk;
  logic nrst;
  logic ce;
  logic [REG_ADDR_WIDTH-1:0] regAddr;
  logic [REG_DATA_WIDTH-1:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [REG_DATA_WIDTH-1:0] regRdata;
  logic [TRIG_COUNT-1:0] trigIn;
  logic cpuReq;
  mem_cmd_s memCmd;
  logic [DATA_WIDTH-1:0] memRdata;
  logic [NUM_CHANNELS-1:0] irqReq;
  logic dmaBusy;
  logic [NUM_CHANNELS-1:0] irqSeen;
  int wrCount;
  int fail_count;
  int checks;

  five_channel_dma u_five_channel_dma (.core_clk(core_clk), .nrst(nrst), .ce(ce),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .trigIn(trigIn), .cpuReq(cpuReq), .memCmd(memCmd),
    .memRdata(memRdata), .irqReq(irqReq), .dmaBusy(dmaBusy));
  mem_partner u_mem_partner (.core_clk(core_clk), .memCmd(memCmd), .memRdata(memRdata));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (memCmd.en && memCmd.write) begin
      wrCount <= wrCount + 1;
    end
    irqSeen <= irqSeen | irqReq;
  end

  task automatic conclude();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    chk(regRdata, exp, what);
  endtask

  task automatic clr();
    @(posedge core_clk);
    #1;
    wrCount = 0;
    irqSeen = '0;
  endtask

  task automatic pulse(input int k);
    @(posedge core_clk);
    trigIn <= 31'h1 << k;
    @(posedge core_clk);
    trigIn <= '0;
  endtask

  // Waits until the engine has been silent long enough to cover the grant latency.
  task automatic waitq();
    int q;
    q = 0;
    for (int i = 0; i < 500; i++) begin
      @(posedge core_clk);
      #1;
      q = (dmaBusy || memCmd.en) ? 0 : q + 1;
      if (q == 12) begin
        return;
      end
    end
    fail_count++;
    conclude();
  endtask

  function automatic chan_cfg_s mk(input logic [4:0] t, input xfer_mode_e m,
    input logic [2:0] v, input logic w, input logic lw, input addr_step_e ss,
    input addr_step_e ds, input logic [1:0] p, input logic k);
    return '{k, p, ds, ss, lw, w, v, m, t};
  endfunction

  task automatic setup(input int ch, input logic [15:0] s, input logic [15:0] d,
    input logic [12:0] lim, input chan_cfg_s c);
    logic [5:0] b;
    b = REG_CH_BASE_WORD + 6'(ch);
    wr({b, CH_SRC_OFS}, {16'h0000, s});
    wr({b, CH_DST_OFS}, {16'h0000, d});
    wr({b, CH_LIMIT_OFS}, {19'h00000, lim});
    wr({b, CH_CFG_OFS}, {13'h0000, c});
  endtask

  task automatic t_reset();
    rd(REG_CHANNEL_ARM, 32'h0, "arm");
    rd(REG_COMPLETION_FLAG, 32'h0, "flag");
    rd(8'hFF, 32'h0, "unmapped");
    @(posedge core_clk);
    ce <= 1'b0;
    wr(REG_CHANNEL_ARM, 32'h01);
    @(posedge core_clk);
    ce <= 1'b1;
    rd(REG_CHANNEL_ARM, 32'h0, "frozen arm");
    clr();
    wr(REG_SOFT_REQUEST, 32'h01);
    waitq();
    chk(wrCount, 0, "unarmed writes");
    rd(REG_SOFT_REQUEST, 32'h0, "unarmed pending");
  endtask

  task automatic t_block();
    setup(1, 16'h0020, 16'h0080, 13'h3,
      mk(5'h05, TM_BLOCK, VARIABLE_LENGTH_OPTION_FIXED, 1'b0, 1'b0, STEP_ONE, STEP_ONE, PRIO_NORMAL, 1'b1));
    clr();
    wr(REG_CHANNEL_ARM, 32'h02);
    pulse(5);
    waitq();
    for (int i = 0; i < 3; i++) begin
      chk(u_mem_partner.mem[8'h80 + i], 8'h20 + i, "block data");
    end
    chk(wrCount, 3, "block count");
    chk(irqSeen, 5'h02, "block irq");
    rd(REG_COMPLETION_FLAG, 32'h02, "block flag");
    rd(REG_CHANNEL_ARM, 32'h0, "block disarm");
    wr(REG_COMPLETION_FLAG, 32'h02);
  endtask

  task automatic t_repeat();
    setup(2, 16'h0030, 16'h0090, 13'h2,
      mk(5'h00, TM_REP_SINGLE, VARIABLE_LENGTH_OPTION_FIXED, 1'b1, 1'b0, STEP_NONE, STEP_TWO, PRIO_NORMAL, 1'b0));
    clr();
    wr(REG_CHANNEL_ARM, 32'h04);
    wr(REG_SOFT_REQUEST, 32'h04);
    waitq();
    chk(wrCount, 1, "single step");
    wr(REG_SOFT_REQUEST, 32'h04);
    waitq();
    chk({u_mem_partner.mem[8'h93], u_mem_partner.mem[8'h92], u_mem_partner.mem[8'h91],
      u_mem_partner.mem[8'h90]}, 32'h31303130, "word data");
    chk(irqSeen, 5'h00, "masked irq");
    rd(REG_COMPLETION_FLAG, 32'h04, "masked flag");
    rd(REG_CHANNEL_ARM, 32'h04, "rearmed");
    u_mem_partner.mem[8'h30] = 8'h55;
    wr(REG_SOFT_REQUEST, 32'h04);
    waitq();
    chk(u_mem_partner.mem[8'h90], 8'h55, "pointer reload");
    wr(REG_CHANNEL_ARM, 32'h84);
  endtask

  task automatic t_variable_length_option();
    int rows [6][4] = '{'{1, 1, 10, 4}, '{2, 1, 10, 3}, '{3, 1, 10, 5}, '{4, 1, 10, 6},
      '{1, 0, 10, 10}, '{1, 1, 2, 2}};
    @(posedge core_clk);
    cpuReq <= 1'b1;
    foreach (rows[r]) begin
      setup(0, 16'h0000, 16'h00F0, 13'(rows[r][2]), mk(5'h00, TM_BLOCK, 3'(rows[r][0]),
        1'b0, rows[r][1][0], STEP_ONE, STEP_BACK, PRIO_HIGH, 1'b1));
      clr();
      wr(REG_CHANNEL_ARM, 32'h01);
      wr(REG_SOFT_REQUEST, 32'h01);
      waitq();
      chk(wrCount, rows[r][3], "variable_length_option count");
      chk(u_mem_partner.mem[8'hF0], (rows[r][0] == 2) ? 8'h01 : 8'h83, "variable_length_option first");
    end
    @(posedge core_clk);
    cpuReq <= 1'b0;
  endtask

  task automatic t_prio();
    setup(3, 16'h0020, 16'h00A0, 13'h1,
      mk(5'h00, TM_SINGLE, VARIABLE_LENGTH_OPTION_FIXED, 1'b0, 1'b0, STEP_ONE, STEP_ONE, PRIO_LOW, 1'b1));
    @(posedge core_clk);
    cpuReq <= 1'b1;
    clr();
    wr(REG_CHANNEL_ARM, 32'h08);
    wr(REG_SOFT_REQUEST, 32'h08);
    waitq();
    chk(wrCount, 0, "low yields");
    rd(REG_SOFT_REQUEST, 32'h08, "still pending");
    @(posedge core_clk);
    cpuReq <= 1'b0;
    waitq();
    chk(wrCount, 1, "low proceeds");
    chk(irqSeen, 5'h08, "low irq");
    chk(u_mem_partner.mem[8'hA0], 8'h20, "low data");
    setup(3, 16'h0021, 16'h00A1, 13'h1,
      mk(5'h00, TM_SINGLE, VARIABLE_LENGTH_OPTION_FIXED, 1'b0, 1'b0, STEP_ONE, STEP_ONE, PRIO_NORMAL, 1'b1));
    @(posedge core_clk);
    cpuReq <= 1'b1;
    clr();
    wr(REG_CHANNEL_ARM, 32'h08);
    wr(REG_SOFT_REQUEST, 32'h08);
    waitq();
    chk(wrCount, 1, "normal wins");
    chk(u_mem_partner.mem[8'hA1], 8'h21, "normal data");
    @(posedge core_clk);
    cpuReq <= 1'b0;
  endtask

  task automatic t_abort();
    setup(0, 16'h0020, 16'h00B0, 13'h2,
      mk(5'h07, TM_BLOCK, VARIABLE_LENGTH_OPTION_FIXED, 1'b0, 1'b0, STEP_ONE, STEP_ONE, PRIO_NORMAL, 1'b1));
    setup(1, 16'h0020, 16'h00C0, 13'h2,
      mk(5'h07, TM_BLOCK, VARIABLE_LENGTH_OPTION_FIXED, 1'b0, 1'b0, STEP_ONE, STEP_ONE, PRIO_NORMAL, 1'b1));
    wr(REG_CHANNEL_ARM, 32'h03);
    wr(REG_CHANNEL_ARM, 32'h81);
    rd(REG_CHANNEL_ARM, 32'h02, "abort select");
    wr(REG_CHANNEL_ARM, 32'h01);
    clr();
    pulse(7);
    waitq();
    chk(wrCount, 4, "shared trigger");
    chk(irqSeen, 5'h03, "both irq");
    chk({u_mem_partner.mem[8'hB1], u_mem_partner.mem[8'hB0], u_mem_partner.mem[8'hC1],
      u_mem_partner.mem[8'hC0]}, 32'h21202120, "both data");
    rd(REG_CHANNEL_ARM, 32'h0, "both disarmed");
    rd(REG_ENGINE_STATUS, 32'h01, "last channel");
  endtask

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    regAddr = '0;
    regWdata = '0;
    regWrite = 1'b0;
    regRead = 1'b0;
    trigIn = '0;
    cpuReq = 1'b0;
    fail_count = 0;
    checks = 0;
    wrCount = 0;
    irqSeen = '0;
    for (int i = 0; i < 256; i++) begin
      u_mem_partner.mem[i] = 8'(i);
    end
    u_mem_partner.mem[0] = 8'h83;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_block();
    t_repeat();
    t_variable_length_option();
    t_prio();
    t_abort();
    wr(REG_CHANNEL_ARM, 32'h9F);
    waitq();
    conclude();
  end
endmodule
